/* File: hdl/lcd_drive_pkg.sv */
// package of the display drive control block: register map, field layouts,
// reset values, drive levels and timing counts.
// assumes a classic wishbone bus with byte addresses and 32-bit data.
package lcd_drive_pkg;

  // ==========================================================================
  // register map (byte addresses, one aligned word each)
  // ==========================================================================
  localparam logic [7:0] OFS_CTRL = 8'h00; // display_control
  localparam logic [7:0] OFS_PHASE = 8'h04; // display_phase
  localparam logic [7:0] OFS_REF = 8'h08; // display_reference_control
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c; // sticky events, cleared by read
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10; // same layout as status
  localparam logic [7:0] OFS_PIX = 8'h40; // first of the pixel_data_regs
  localparam int PIX_REGS = 12; // 3 segment bytes x 4 commons
  localparam int SEG_N = 24; // segment lines
  localparam int COM_N = 4; // common lines

  // ==========================================================================
  // reset values and write masks
  // ==========================================================================
  localparam logic [7:0] CTRL_RST = 8'h03; // four commons after reset
  localparam logic [7:0] PHASE_RST = 8'h03; // prescale 1:4 after reset
  localparam logic [7:0] REF_RST = 8'h00;
  localparam logic [7:0] REF_WMASK = 8'hae; // implemented bits 7,5,3,2,1
  localparam logic [1:0] IRQ_RST = 2'h0;

  // interrupt status bit positions
  localparam int IRQ_WFAIL = 0; // rejected pixel write
  localparam int IRQ_FRAME = 1; // frame boundary passed

  // control fields, bit 7 down to bit 0
  typedef struct packed {
    logic driver_enable; // bit 7
    logic sleep_disable; // bit 6
    logic write_fail_flag; // bit 5
    logic unused4; // bit 4, always zero
    logic [1:0] clock_source; // bits 3-2
    logic [1:0] commons_select; // bits 1-0
  } ctrl_t;

  // phase fields, bit 7 down to bit 0
  typedef struct packed {
    logic waveform_type; // bit 7
    logic bias_select; // bit 6
    logic driver_active_status; // bit 5, live status
    logic write_allow_status; // bit 4, live status
    logic [3:0] frame_prescale; // bits 3-0
  } phase_t;

  // position of the scan inside a frame
  typedef struct packed {
    logic [1:0] com_idx; // common being driven
    logic half; // second half of the common period
    logic frame_phase; // inverts each frame
  } frame_pos_t;

  // drive voltage level code of a common or segment line
  typedef enum logic [1:0] {
    LVL_V0 = 2'b00,
    LVL_V1 = 2'b01,
    LVL_V2 = 2'b10,
    LVL_V3 = 2'b11
  } drive_level_t;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int FOSC_DIV = 256; // system clock divider for source 00
  localparam logic [7:0] FOSC_LAST = 8'(FOSC_DIV - 1);
  localparam logic [1:0] CS_FOSC = 2'b00;
  localparam logic [1:0] CS_TIMER1 = 2'b01;

endpackage

/* File: hdl/lcd_tick_divider.sv */
// divider that turns pulses of the selected module clock into scan steps.
// assumes src_tick_i is a one-cycle pulse synchronous to clk_i.
module lcd_tick_divider (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic src_tick_i,
  input wire logic [3:0] div_code_i,
  output logic tick_o
);
  import lcd_drive_pkg::*;

  // ==========================================================================
  // prescale counter
  // ==========================================================================
  logic [3:0] cnt_ff; // source pulses seen since last step
  logic tick_ff; // registered step pulse

  // counts code+1 source pulses per step; restarts while stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 4'h0;
      tick_ff <= 1'b0;
    end else if (ce_i) begin
      tick_ff <= 1'b0;
      if (!run_i) begin
        cnt_ff <= 4'h0; // stopped: start clean on next enable
      end else if (src_tick_i) begin
        if (cnt_ff >= div_code_i) begin
          cnt_ff <= 4'h0;
          tick_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end
    end
  end

  assign tick_o = tick_ff;

  // a step comes only on a source pulse seen in the previous cycle
  property p_tick_cause;
    @(posedge clk_i) disable iff (rst_i)
      tick_o |-> $past(src_tick_i) && $past(run_i);
  endproperty
  a_tick_cause: assert property (p_tick_cause) else $error("step without source pulse");

endmodule

/* File: hdl/lcd_drive_control.sv */
// control, status and scan logic of a segment display driver.
// assumes timer1 and low-frequency oscillator arrive as one-cycle enable
// pulses in clk_i's domain, and sleep_i is a synchronous level.
//
// Operation
// - enable bit switches driver on and off
// - sleep_disable set stops driver during sleep
// - rejected pixel write raises sticky write-fail flag
// - clock source: fosc/256, timer1, low-freq oscillator
// - commons_select sets one to four commons
// - waveform type: invert per frame or within common
// - bias one half, zero third; four commons third
// - active status reads one while driver runs
// - write-allow status reads one when writes accepted
// - prescaler divides module clock by code plus one
// - control bit four reads zero, ignores writes
// - reference register top bit enables internal reference
// - enabled reference switched on to contrast circuit
// - pixel bit zero clear, one dark
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
module lcd_drive_control (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic sleep_i,
  input wire logic timer1_osc_tick_i,
  input wire logic low_freq_osc_tick_i,
  output lcd_drive_pkg::drive_level_t com_level_o [lcd_drive_pkg::COM_N],
  output lcd_drive_pkg::drive_level_t seg_level_o [lcd_drive_pkg::SEG_N],
  output logic internal_ref_on_o,
  output logic irq_o
);
  import lcd_drive_pkg::*;

  // ==========================================================================
  // decode helpers
  // ==========================================================================
  // true for a word address inside the pixel data window
  function automatic logic is_pixel(input logic [7:0] adr);
    is_pixel = (adr >= OFS_PIX) && (adr < 8'(OFS_PIX + 4 * PIX_REGS)) && (adr[1:0] == 2'b00);
  endfunction

  // index of a pixel data register from its address
  function automatic logic [3:0] pixel_index(input logic [7:0] adr);
    logic [7:0] rel;
    rel = adr - OFS_PIX;
    pixel_index = rel[5:2];
  endfunction

  // ==========================================================================
  // state
  // ==========================================================================
  ctrl_t ctrl_ff; // display_control
  phase_t phase_ff; // display_phase, status bits unused in storage
  logic [7:0] ref_ff; // display_reference_control
  logic [1:0] irq_stat_ff; // sticky events
  logic [1:0] irq_mask_ff; // event enables
  logic [7:0] pixel_ff [PIX_REGS]; // software pixel bytes
  logic [7:0] shadow_ff [PIX_REGS]; // bytes shown in the current frame
  logic ack_ff; // bus answer
  logic [31:0] rd_ff; // read data
  logic [7:0] fosc_cnt_ff; // system clock prescaler
  frame_pos_t pos_ff; // scan position
  drive_level_t com_ff [COM_N]; // registered common levels
  drive_level_t seg_ff [SEG_N]; // registered segment levels

  logic req; // new bus request this cycle
  logic wr; // write to the low byte lane
  logic rd; // read request
  logic pix_wr; // pixel data write attempt
  logic pix_fail; // pixel write while not allowed
  logic active; // driver running
  logic write_allow; // pixel writes accepted now
  logic fosc_tick; // system clock divided by 256
  logic src_tick; // selected module clock pulse
  logic step; // prescaled scan step
  logic frame_end; // last step of a frame
  logic phase_now; // drive polarity of the current step
  logic [7:0] ctrl_rd; // control as read back
  logic [7:0] phase_rd; // phase as read back

  // ==========================================================================
  // wishbone classic slave
  // ==========================================================================
  // one answer per request; ack drops in the cycle after it is given
  assign req = cyc_i & stb_i & ~ack_ff;
  assign wr = req & we_i & sel_i[0];
  assign rd = req & ~we_i;
  assign pix_wr = wr & is_pixel(adr_i);
  assign pix_fail = pix_wr & ~write_allow;

  // ack one cycle after the request is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else if (ce_i) begin
      ack_ff <= req;
    end
  end

  // read views: bit four always zero, live status in the phase byte
  always_comb begin
    ctrl_rd = ctrl_ff;
    ctrl_rd[4] = 1'b0;
    phase_rd = phase_ff;
    phase_rd[5] = active;
    phase_rd[4] = write_allow;
  end

  // read mux; unmapped addresses answer zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_ff <= 32'h0000_0000;
    end else if (ce_i && rd) begin
      if (adr_i == OFS_CTRL) begin
        rd_ff <= {24'h00_0000, ctrl_rd};
      end else if (adr_i == OFS_PHASE) begin
        rd_ff <= {24'h00_0000, phase_rd};
      end else if (adr_i == OFS_REF) begin
        rd_ff <= {24'h00_0000, ref_ff};
      end else if (adr_i == OFS_IRQ_STAT) begin
        rd_ff <= {30'h0000_0000, irq_stat_ff};
      end else if (adr_i == OFS_IRQ_MASK) begin
        rd_ff <= {30'h0000_0000, irq_mask_ff};
      end else if (is_pixel(adr_i)) begin
        rd_ff <= {24'h00_0000, pixel_ff[pixel_index(adr_i)]};
      end else begin
        rd_ff <= 32'h0000_0000; // hole in the map
      end
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = rd_ff;

  // ==========================================================================
  // control register
  // ==========================================================================
  // write-fail is clear-only by software; a new failure beats the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= ctrl_t'(CTRL_RST);
    end else if (ce_i) begin
      if (wr && adr_i == OFS_CTRL) begin
        ctrl_ff.driver_enable <= dat_i[7];
        ctrl_ff.sleep_disable <= dat_i[6];
        ctrl_ff.clock_source <= dat_i[3:2];
        ctrl_ff.commons_select <= dat_i[1:0];
        if (!dat_i[5]) begin
          ctrl_ff.write_fail_flag <= 1'b0; // writing one cannot set it
        end
      end
      if (pix_fail) begin
        ctrl_ff.write_fail_flag <= 1'b1;
      end
      ctrl_ff.unused4 <= 1'b0;
    end
  end

  // ==========================================================================
  // phase and reference registers
  // ==========================================================================
  // status bits are never stored; they are taken live on read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_ff <= phase_t'(PHASE_RST);
    end else if (ce_i && wr && adr_i == OFS_PHASE) begin
      phase_ff.waveform_type <= dat_i[7];
      phase_ff.bias_select <= dat_i[6];
      phase_ff.frame_prescale <= dat_i[3:0];
    end
  end

  // only implemented bits take a write, the rest stay zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_ff <= REF_RST;
    end else if (ce_i && wr && adr_i == OFS_REF) begin
      ref_ff <= dat_i[7:0] & REF_WMASK;
    end
  end

  // no analog here: the enable goes to the reference and contrast switch
  assign internal_ref_on_o = ref_ff[7];

  // ==========================================================================
  // pixel data
  // ==========================================================================
  // rejected writes leave the byte alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < PIX_REGS; i++) begin
        pixel_ff[i] <= 8'h00;
      end
    end else if (ce_i && pix_wr && write_allow) begin
      pixel_ff[pixel_index(adr_i)] <= dat_i[7:0];
    end
  end

  // shadow copy taken at each frame end so a frame never tears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < PIX_REGS; i++) begin
        shadow_ff[i] <= 8'h00;
      end
    end else if (ce_i && (!active || frame_end)) begin
      shadow_ff <= pixel_ff;
    end
  end

  // ==========================================================================
  // interrupts
  // ==========================================================================
  // a read of the status clears it; an event in the same cycle survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= IRQ_RST;
      irq_mask_ff <= IRQ_RST;
    end else if (ce_i) begin
      if (wr && adr_i == OFS_IRQ_MASK) begin
        irq_mask_ff <= dat_i[1:0];
      end
      irq_stat_ff <= (rd && adr_i == OFS_IRQ_STAT) ? 2'b00 : irq_stat_ff;
      if (pix_fail) begin
        irq_stat_ff[IRQ_WFAIL] <= 1'b1;
      end
      if (frame_end) begin
        irq_stat_ff[IRQ_FRAME] <= 1'b1;
      end
    end
  end

  assign irq_o = |(irq_stat_ff & irq_mask_ff);

  // ==========================================================================
  // module clock selection and prescaler
  // ==========================================================================
  assign active = ctrl_ff.driver_enable & ~(sleep_i & ctrl_ff.sleep_disable);

  // free-running divide by 256 of the system clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fosc_cnt_ff <= 8'h00;
    end else if (ce_i) begin
      fosc_cnt_ff <= fosc_cnt_ff + 8'h01;
    end
  end

  assign fosc_tick = (fosc_cnt_ff == FOSC_LAST);

  // source select: 1x means low-frequency oscillator
  always_comb begin
    if (ctrl_ff.clock_source == CS_FOSC) begin
      src_tick = fosc_tick;
    end else if (ctrl_ff.clock_source == CS_TIMER1) begin
      src_tick = timer1_osc_tick_i;
    end else begin
      src_tick = low_freq_osc_tick_i;
    end
  end

  lcd_tick_divider u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(active),
    .src_tick_i(src_tick),
    .div_code_i(phase_ff.frame_prescale),
    .tick_o(step)
  );

  // ==========================================================================
  // scan sequencer
  // ==========================================================================
  // writes are held off through the last half of the last common, whose step copies the shadow
  assign frame_end = active & step & pos_ff.half & (pos_ff.com_idx == ctrl_ff.commons_select);
  assign write_allow = ~(active & pos_ff.half & (pos_ff.com_idx == ctrl_ff.commons_select));

  // two halves per common, commons in turn, frame polarity flips at wrap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_ff <= '0;
    end else if (ce_i) begin
      if (!active) begin
        pos_ff <= '0;
      end else if (pos_ff.com_idx > ctrl_ff.commons_select) begin
        // commons cut down mid-frame: restart the scan at the first one
        pos_ff.com_idx <= 2'b00;
        pos_ff.half <= 1'b0;
      end else if (step) begin
        pos_ff.half <= ~pos_ff.half;
        if (pos_ff.half) begin
          if (pos_ff.com_idx == ctrl_ff.commons_select) begin
            pos_ff.com_idx <= 2'b00;
            pos_ff.frame_phase <= ~pos_ff.frame_phase;
          end else begin
            pos_ff.com_idx <= pos_ff.com_idx + 2'b01;
          end
        end
      end
    end
  end

  // type B holds polarity for the frame, type A flips it mid-common
  assign phase_now = phase_ff.waveform_type ? pos_ff.frame_phase : pos_ff.half;

  // ==========================================================================
  // line drivers
  // ==========================================================================
  // selected common swings full; the other scanned ones sit at a middle level
  // which depends on bias; static mode has no middle level at all
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < COM_N; c++) begin
        com_ff[c] <= LVL_V0;
      end
    end else if (ce_i) begin
      for (int c = 0; c < COM_N; c++) begin
        if (!active || c > int'(ctrl_ff.commons_select)) begin
          com_ff[c] <= LVL_V0; // off or unused common
        end else if (c == int'(pos_ff.com_idx)) begin
          com_ff[c] <= phase_now ? LVL_V3 : LVL_V0;
        end else if (phase_ff.bias_select && ctrl_ff.commons_select != 2'b11) begin
          com_ff[c] <= LVL_V1;
        end else begin
          com_ff[c] <= phase_now ? LVL_V1 : LVL_V2;
        end
      end
    end
  end

  // dark pixels oppose the selected common, clear ones stay near it
  genvar s;
  generate
    for (s = 0; s < SEG_N; s++) begin : g_seg
      logic dark; // pixel of this segment on the selected common
      assign dark = shadow_ff[int'(pos_ff.com_idx) * 3 + s / 8][s % 8];
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          seg_ff[s] <= LVL_V0;
        end else if (ce_i) begin
          if (!active) begin
            seg_ff[s] <= LVL_V0;
          end else if (dark) begin
            seg_ff[s] <= phase_now ? LVL_V0 : LVL_V3;
          end else if (ctrl_ff.commons_select == 2'b00 ||
                       (phase_ff.bias_select && ctrl_ff.commons_select != 2'b11)) begin
            seg_ff[s] <= phase_now ? LVL_V3 : LVL_V0;
          end else begin
            seg_ff[s] <= phase_now ? LVL_V2 : LVL_V1;
          end
        end
      end
    end
  endgenerate

  assign com_level_o = com_ff;
  assign seg_level_o = seg_ff;

  // ==========================================================================
  // checks
  // ==========================================================================
  property p_off_quiet;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && !ctrl_ff.driver_enable |-> !phase_rd[5] ##1 com_level_o[0] == LVL_V0;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("driver not off");

  property p_sleep_stop;
    @(posedge clk_i) disable iff (rst_i)
      sleep_i && ctrl_ff.sleep_disable |-> !active && pos_ff == '0 || $past(active);
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("driver runs in sleep");

  property p_wfail_set;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && pix_fail |=> ctrl_ff.write_fail_flag && irq_stat_ff[IRQ_WFAIL];
  endproperty
  a_wfail_set: assert property (p_wfail_set) else $error("write fail not flagged");

  property p_src_fosc;
    @(posedge clk_i) disable iff (rst_i)
      ctrl_ff.clock_source == CS_FOSC |-> src_tick == (fosc_cnt_ff == 8'hff);
  endproperty
  a_src_fosc: assert property (p_src_fosc) else $error("wrong clock source");

  property p_com_range;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && pos_ff.com_idx > ctrl_ff.commons_select |=>
        pos_ff.com_idx <= ctrl_ff.commons_select;
  endproperty
  a_com_range: assert property (p_com_range) else $error("common past selection");

  sequence s_mid_frame_step;
    ce_i && active && step && phase_ff.waveform_type && !pos_ff.half;
  endsequence
  property p_typeb_hold;
    @(posedge clk_i) disable iff (rst_i)
      s_mid_frame_step ##1 active && phase_ff.waveform_type |-> $stable(phase_now);
  endproperty
  a_typeb_hold: assert property (p_typeb_hold) else $error("type B flipped mid frame");

  property p_reject_keep;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && pix_fail |=> pixel_ff[$past(pixel_index(adr_i))] == $past(pixel_ff[pixel_index(adr_i)]);
  endproperty
  a_reject_keep: assert property (p_reject_keep) else $error("rejected write stored");

  property p_bit4_zero;
    @(posedge clk_i) disable iff (rst_i)
      rd && adr_i == OFS_CTRL && ce_i |=> ack_o && dat_o[4] == 1'b0;
  endproperty
  a_bit4_zero: assert property (p_bit4_zero) else $error("control bit four not zero");

  property p_ref_on;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && wr && adr_i == OFS_REF |=> internal_ref_on_o == $past(dat_i[7]);
  endproperty
  a_ref_on: assert property (p_ref_on) else $error("reference enable wrong");

endmodule

/* File: bench/lcd_panel_model.sv */
// panel stand-in: notes which commons were ever driven to the top level.
// assumes the level coding of the drive package and the block's clock.
module lcd_panel_model
  import lcd_drive_pkg::*;
(
  input wire logic clk_i,
  input wire logic clr_i,
  input wire lcd_drive_pkg::drive_level_t com_i [lcd_drive_pkg::COM_N],
  output logic [3:0] seen_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // scan watch
  // ==========================================================================
  // unselected scanned commons sit at mid levels and unused ones at v0, so only a scanned one reaches v3
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < COM_N; k++) begin
      if (clr_i) begin
        seen_o[k] <= 1'b0;
      end else if (com_i[k] == LVL_V3) begin
        seen_o[k] <= 1'b1;
      end
    end
  end
endmodule

/* File: bench/tb_top.sv */
// bench of the display drive control block: wishbone tasks and checks.
// assumes the panel model beside the block and a 20 MHz clock.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lcd_drive_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, slp = 0, t1 = 0, lf = 0, clr = 0;
  logic [7:0] adr = 0;
  logic [31:0] wdat = 0, rdat, q;
  logic ack, ref_on, irq;
  logic [3:0] seen;
  drive_level_t com [COM_N];
  drive_level_t seg [SEG_N];
  int failures = 0, cmp_count = 0, n;
  // ==========================================================================
  // clock, block and panel
  // ==========================================================================
  always #25 clk = ~clk;
  lcd_drive_control dut (.clk_i(clk), .rst_i(rst), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .sleep_i(slp), .timer1_osc_tick_i(t1), .low_freq_osc_tick_i(lf), .com_level_o(com),
    .seg_level_o(seg), .internal_ref_on_o(ref_on), .irq_o(irq));
  lcd_panel_model panel (.clk_i(clk), .clr_i(clr), .com_i(com), .seen_o(seen));
  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic test_done();
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle; ack is awaited, never assumed
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) begin
      failures++;
      test_done();
    end else begin
      q = rdat;
    end
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask
  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(0, OFS_CTRL, 0); check(q, 32'h03);
    bus(0, OFS_PHASE, 0); check(q, 32'h13);
    bus(0, 8'h20, 0); check(q, 32'h0);
    bus(1, OFS_CTRL, 8'h73); bus(0, OFS_CTRL, 0); check(q, 32'h43);
    bus(1, OFS_REF, 8'hff); bus(0, OFS_REF, 0); check(q, 32'hae);
    check(ref_on, 1);
    lf <= 1'b1; // low-freq pulse every cycle
    bus(1, OFS_PHASE, 8'h0f);
    bus(1, OFS_CTRL, 8'hcf); bus(0, OFS_PHASE, 0); check(q & 32'hef, 32'h2f);
    slp <= 1'b1;
    bus(0, OFS_PHASE, 0); check(q & 32'h20, 0);
    bus(1, OFS_CTRL, 8'h8f); bus(0, OFS_PHASE, 0); check(q & 32'h20, 32'h20);
    slp <= 1'b0;
    bus(1, OFS_IRQ_MASK, 8'h00);
    n = 0;
    // hunt for the closed write window near frame end
    do begin
      bus(0, OFS_PHASE, 0);
      n++;
    end while (q[4] !== 1'b0 && n < 200);
    check(q[4], 0);
    bus(1, OFS_PIX, 8'hff); bus(0, OFS_CTRL, 0); check(q, 32'haf);
    check(irq, 0);
    bus(1, OFS_IRQ_MASK, 8'h01); check(irq, 1);
    bus(0, OFS_IRQ_STAT, 0); check(q & 32'h1, 1);
    check(irq, 0);
    bus(1, OFS_CTRL, 8'h8f); bus(0, OFS_CTRL, 0); check(q, 32'h8f);
    bus(1, OFS_CTRL, 8'h0f); bus(0, OFS_PHASE, 0); check(q, 32'h1f);
    t1 <= 1'b1;
    // clock source i with commons code i, for i from 0 to 3, waveform type alternating
    for (int i = 0; i < 4; i++) begin
      bus(1, OFS_PHASE, {i[0], 7'h0});
      bus(1, OFS_CTRL, {4'h8, i[1:0], i[1:0]});
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (1500) @(posedge clk);
      check(seen, 32'((1 << (i + 1)) - 1));
    end
    // drop to one common while four are being scanned
    bus(1, OFS_CTRL, 8'h8c);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (100) @(posedge clk);
    check(seen, 32'h1);
    // rejected byte stayed clear; an idle driver takes pixel writes
    bus(1, OFS_CTRL, 8'h0c); bus(0, OFS_PIX, 0); check(q, 32'h0);
    bus(1, OFS_PIX, 8'h01); bus(0, OFS_PIX, 0); check(q, 32'h01);
    // static drive: dark segment opposes the common, clear one follows it
    bus(1, OFS_CTRL, 8'h8c);
    repeat (4) @(posedge clk);
    check({seg[0], seg[1]}, {~com[0], com[0]});
    test_done();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    test_done();
  end
endmodule
